//--- rtl/t1lb_top.sv
// Purpose: loopback steering for one t1/e1 channel between line unit, framer and backplane
// Assumes: line clocks and pin data are sampled by pclk; framer-side signals share pclk
// Notes:   the transmit line pair changes on detected edges of the clock in force
`timescale 1ns/1ns

// What this block does
// - framer loop sends transmit data to receive
// - framer loop: t1 all-ones, e1 normal data
// - framer loop ignores rx line, uses tx clock
// - payload loop: transmit timed from receive clock
// - payload loop: chan clock/block low, inputs ignored
// - t1 payload loop regenerates framing, crc6, fdl
// - e1 payload loop regenerates fas, si, sa, crc4
// - remote loop retransmits rx line data
// - local loop feeds tx data via jitter attenuator
// - pin high or select set: mux bit decides
// - select zero, pin low: always separated
// - select bit picks mux or power-down role
// - enabled channels take received data
// - four enable registers map channels in order
// - any channel combination may loop
module t1lb_top import t1lb_pkg::*; (
    // clock, reset, enable
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    // apb
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [T1LB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // line pins
    input  wire logic                   tx_line_clock,
    input  wire logic                   rx_recovered_clock_in,
    input  wire logic                   rx_line_pos_in,
    input  wire logic                   rx_line_neg_in,
    input  wire logic                   rx_analog_pos,
    input  wire logic                   rx_analog_neg,
    input  wire logic                   shared_mux_powerdown_pin,
    output logic                        tx_line_pos_out,
    output logic                        tx_line_neg_out,
    output logic                        tx_power_down,
    output logic                        line_unit_connected,
    // backplane pins
    input  wire logic                   tx_serial_in,
    input  wire logic                   tx_signaling_in,
    output logic                        tx_channel_clock,
    output logic                        tx_channel_block,
    output logic                        tx_link_clock,
    // framer side, same clock
    input  wire logic                   e1_mode,
    input  wire t1lb_pair_t             fmt_line,
    input  wire logic                   fmt_overhead,
    input  wire logic [T1LB_SLOT_W-1:0] tx_slot,
    input  wire logic                   rx_slot_data,
    input  wire logic                   rx_payload_fixed,
    input  wire logic                   chan_clock_int,
    input  wire logic                   chan_block_int,
    output logic                        tx_serial_to_fmt,
    output logic                        tx_signaling_to_fmt,
    output t1lb_pair_t                  rx_to_framer,
    output logic                        rx_framer_tick,
    output logic                        tx_framer_tick,
    output logic                        jitter_atten_tx_src,
    output t1lb_mode_t                  loop_mode
);

    t1lb_lbctl_t            lbctl;
    logic [T1LB_CHANNELS-1:0] chan_en;
    logic [7:0]             status;
    logic [8:0]             raw_pins;
    logic [8:0]             pins;
    logic                   txc_s;
    logic                   rxc_s;
    t1lb_pair_t             rx_line_s;
    t1lb_pair_t             rx_analog_s;
    logic                   tx_serial_in_s;
    logic                   tx_signaling_in_s;
    logic                   mux_pin_s;
    logic                   txc_prev;
    logic                   rxc_prev;
    logic                   tx_rise;
    logic                   rx_rise;
    logic                   tx_edge;
    logic                   rx_edge;
    t1lb_mode_t             next_mode;
    logic                   ones_phase;
    logic                   next_connected;

    assign raw_pins = {tx_line_clock, rx_recovered_clock_in, rx_line_pos_in, rx_line_neg_in,
                       rx_analog_pos, rx_analog_neg, tx_serial_in, tx_signaling_in,
                       shared_mux_powerdown_pin};
    assign {txc_s, rxc_s, rx_line_s, rx_analog_s, tx_serial_in_s, tx_signaling_in_s, mux_pin_s} = pins;

    // all pin inputs share one synchroniser bank
    t1lb_sync #(
        .WIDTH (9)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .async_in (raw_pins),
        .sync_out (pins)
    );

    // register file; status shows the mode in force and the mux state
    assign status = {1'b0, loop_mode, 2'h0, tx_power_down, line_unit_connected};

    t1lb_regs u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .lbctl   (lbctl),
        .chan_en (chan_en),
        .status  (status)
    );

    always_comb begin
        if (lbctl.remote_loop_enable) begin
            next_mode = T1LB_REMOTE;
        end else if (lbctl.payload_loop_enable) begin
            next_mode = T1LB_PAYLOAD;
        end else if (lbctl.framer_loop_enable) begin
            next_mode = T1LB_FRAMER;
        end else if (lbctl.local_loop_enable) begin
            next_mode = T1LB_LOCAL;
        end else begin
            next_mode = T1LB_NORMAL;
        end
    end

    // pin or select hands control to the mux bit
    assign next_connected = (lbctl.mux_pin_function_sel || mux_pin_s) && !lbctl.line_unit_mux_ctrl;

    // mode and mux state registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_mode           <= T1LB_NORMAL;
            line_unit_connected <= 1'b0;
            tx_power_down       <= 1'b0;
            jitter_atten_tx_src <= 1'b0;
        end else if (ce) begin
            loop_mode           <= next_mode;
            line_unit_connected <= next_connected;
            tx_power_down       <= lbctl.mux_pin_function_sel && mux_pin_s;
            // local loop through the jitter attenuator
            jitter_atten_tx_src <= (next_mode == T1LB_LOCAL);
        end
    end

    // line clock edge detection on synchronised copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txc_prev <= 1'b0;
            rxc_prev <= 1'b0;
        end else if (ce) begin
            txc_prev <= txc_s;
            rxc_prev <= rxc_s;
        end
    end

    assign tx_rise = txc_s && !txc_prev;
    assign rx_rise = rxc_s && !rxc_prev;

    // payload and remote transmit on the receive clock
    assign tx_edge = (loop_mode == T1LB_PAYLOAD || loop_mode == T1LB_REMOTE) ? rx_rise : tx_rise;
    // framer loop times the receive side from the transmit clock
    assign rx_edge = (loop_mode == T1LB_FRAMER) ? tx_rise : rx_rise;

    // one-cycle ticks tell the framer when each side advances
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_framer_tick <= 1'b0;
            rx_framer_tick <= 1'b0;
        end else if (ce) begin
            tx_framer_tick <= tx_edge;
            rx_framer_tick <= rx_edge;
        end
    end

    // all-ones phase alternates marks so the line stays bipolar
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ones_phase <= 1'b0;
        end else if (ce && tx_edge) begin
            ones_phase <= !ones_phase;
        end
    end

    // transmit line pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_line_pos_out <= 1'b0;
            tx_line_neg_out <= 1'b0;
        end else if (ce && tx_edge) begin
            case (loop_mode)
                T1LB_REMOTE: begin
                    tx_line_pos_out <= rx_line_s.pos;
                    tx_line_neg_out <= rx_line_s.neg;
                end
                // t1 sends unframed all ones, e1 normal data
                T1LB_FRAMER: begin
                    tx_line_pos_out <= e1_mode ? fmt_line.pos : !ones_phase;
                    tx_line_neg_out <= e1_mode ? fmt_line.neg : ones_phase;
                end
                default: begin
                    tx_line_pos_out <= fmt_line.pos;
                    tx_line_neg_out <= fmt_line.neg;
                end
            endcase
        end
    end

    // receive pair toward the framer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_to_framer <= '0;
        end else if (ce && rx_edge) begin
            case (loop_mode)
                T1LB_FRAMER: rx_to_framer <= fmt_line;
                // transmitted data replaces the analogue input
                T1LB_LOCAL:  rx_to_framer <= fmt_line;
                T1LB_NORMAL: rx_to_framer <= next_connected ? rx_analog_s : rx_line_s;
                default:     rx_to_framer <= rx_line_s;
            endcase
        end
    end

    // serial data toward the formatter; overhead slots left to the formatter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_serial_to_fmt <= 1'b0;
        end else if (ce && tx_edge) begin
            if (fmt_overhead) begin
                // t1 framing, crc6 and fdl regenerated
                // e1 fas, si, sa, e and crc4 regenerated
                tx_serial_to_fmt <= 1'b0;
            end else if (loop_mode == T1LB_PAYLOAD) begin
                tx_serial_to_fmt <= rx_payload_fixed;
            end else if (chan_en[tx_slot]) begin
                tx_serial_to_fmt <= rx_slot_data;
            end else begin
                tx_serial_to_fmt <= tx_serial_in_s;
            end
        end
    end

    // payload loop forces channel strobes low, ignores signaling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_channel_clock    <= 1'b0;
            tx_channel_block    <= 1'b0;
            tx_signaling_to_fmt <= 1'b0;
            tx_link_clock       <= 1'b0;
        end else if (ce) begin
            tx_channel_clock    <= (next_mode != T1LB_PAYLOAD) && chan_clock_int;
            tx_channel_block    <= (next_mode != T1LB_PAYLOAD) && chan_block_int;
            tx_signaling_to_fmt <= (next_mode != T1LB_PAYLOAD) && tx_signaling_in_s;
            tx_link_clock       <= (next_mode == T1LB_PAYLOAD) ? rxc_s : txc_s;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    prio_remote_a: assert property (ce && lbctl.remote_loop_enable |=> loop_mode == T1LB_REMOTE)
        else $error("remote loop lost priority");
    prio_payload_a: assert property (ce && !lbctl.remote_loop_enable && lbctl.payload_loop_enable
                                     |=> loop_mode == T1LB_PAYLOAD)
        else $error("payload loop lost priority");
    remote_data_a: assert property (ce && tx_edge && loop_mode == T1LB_REMOTE
                                    |=> tx_line_pos_out == $past(rx_line_s.pos))
        else $error("remote loop data not retransmitted");
    all_ones_a: assert property (ce && tx_edge && loop_mode == T1LB_FRAMER && !e1_mode
                                 |=> tx_line_pos_out != tx_line_neg_out)
        else $error("framer loop not sending all ones");
    framer_rx_a: assert property (ce && rx_edge && loop_mode == T1LB_FRAMER
                                  |=> rx_to_framer == $past(fmt_line))
        else $error("framer loop receive data wrong");
    framer_clock_a: assert property (loop_mode == T1LB_FRAMER |-> rx_edge == tx_rise)
        else $error("framer loop receive timing wrong");
    payload_strobe_a: assert property (ce && next_mode == T1LB_PAYLOAD
                                       |=> !tx_channel_clock && !tx_channel_block)
        else $error("channel strobes not forced low");
    payload_clock_a: assert property (loop_mode == T1LB_PAYLOAD |-> tx_edge == rx_rise)
        else $error("payload loop not on receive clock");
    chan_loop_a: assert property (ce && tx_edge && !fmt_overhead && loop_mode != T1LB_PAYLOAD
                                  && chan_en[tx_slot] |=> tx_serial_to_fmt == $past(rx_slot_data))
        else $error("looped channel not substituted");
    mux_sep_a: assert property (ce && !lbctl.mux_pin_function_sel && !mux_pin_s
                                |=> !line_unit_connected)
        else $error("unit connected with pin low");

    remote_c: cover property (loop_mode == T1LB_REMOTE && tx_edge);
    payload_c: cover property (loop_mode == T1LB_PAYLOAD && tx_edge && !fmt_overhead);
    framer_c: cover property (loop_mode == T1LB_FRAMER && rx_edge);
    chan_c: cover property (tx_edge && chan_en[tx_slot] && loop_mode == T1LB_NORMAL);

endmodule

//--- rtl/t1lb_pkg.sv
// Purpose: shared constants and types for the t1/e1 loopback steering block
// Assumes: 8-bit registers, each on one aligned 32-bit apb word (byte address = index * 4)
// Notes:   register indexes are kept as printed; the block adds a status register
package t1lb_pkg;

    // register indexes and apb geometry
    localparam int          T1LB_ADDR_W      = 12;
    localparam logic [7:0]  T1LB_IDX_LBCTL   = 8'h4A;
    localparam logic [7:0]  T1LB_IDX_CH1_8   = 8'h4B;
    localparam logic [7:0]  T1LB_IDX_CH9_16  = 8'h4C;
    localparam logic [7:0]  T1LB_IDX_CH17_24 = 8'h4D;
    localparam logic [7:0]  T1LB_IDX_CH25_32 = 8'h4E;
    localparam logic [7:0]  T1LB_IDX_STATUS  = 8'h4F;
    localparam logic [7:0]  T1LB_REG_RESET   = 8'h00;
    localparam int          T1LB_CHANNELS    = 32;
    localparam int          T1LB_SLOT_W      = 5;

    // byte address of a register from its index
    function automatic logic [T1LB_ADDR_W-1:0] t1lb_addr(input logic [7:0] idx);
        t1lb_addr = {2'h0, idx, 2'h0};
    endfunction

    // loopback control register layout, msb first
    typedef struct packed {
        logic       mux_pin_function_sel;
        logic [1:0] unused;
        logic       line_unit_mux_ctrl;
        logic       local_loop_enable;
        logic       remote_loop_enable;
        logic       payload_loop_enable;
        logic       framer_loop_enable;
    } t1lb_lbctl_t;

    // one bipolar line pair
    typedef struct packed {
        logic pos;
        logic neg;
    } t1lb_pair_t;

    // whole-path loopback in force after priority
    typedef enum logic [2:0] {
        T1LB_NORMAL,
        T1LB_REMOTE,
        T1LB_PAYLOAD,
        T1LB_FRAMER,
        T1LB_LOCAL
    } t1lb_mode_t;

endpackage

//--- rtl/t1lb_sync.sv
// Purpose: three-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes:   the output changes once the second and third stages agree
`timescale 1ns/1ns
module t1lb_sync import t1lb_pkg::*; #(
    parameter int WIDTH = 1
) (
    // clock, reset, enable
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // asynchronous in, filtered out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // stage1 feeds stage2 only, so metastability never reaches the compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (ce) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // accept a bit only when two settled stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= '0;
        end else if (ce) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    end

endmodule

//--- rtl/t1lb_regs.sv
// Purpose: apb slave holding the loopback and per-channel enable registers
// Assumes: one wait state; 8-bit data in the low byte of a 32-bit word
// Notes:   unmapped addresses answer with pslverr and read zero
`timescale 1ns/1ns
module t1lb_regs import t1lb_pkg::*; (
    // clock, reset, enable
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    // apb
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [T1LB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // register contents and block state
    output t1lb_lbctl_t                 lbctl,
    output logic [T1LB_CHANNELS-1:0]    chan_en,
    input  wire logic [7:0]             status
);

    logic       access;
    logic       commit;
    logic       mapped;
    logic [7:0] rd_byte;

    assign access = psel && penable;
    assign commit = access && pready && ce;

    // address decode and read mux
    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            t1lb_addr(T1LB_IDX_LBCTL):   rd_byte = lbctl;
            t1lb_addr(T1LB_IDX_CH1_8):   rd_byte = chan_en[7:0];
            t1lb_addr(T1LB_IDX_CH9_16):  rd_byte = chan_en[15:8];
            t1lb_addr(T1LB_IDX_CH17_24): rd_byte = chan_en[23:16];
            t1lb_addr(T1LB_IDX_CH25_32): rd_byte = chan_en[31:24];
            t1lb_addr(T1LB_IDX_STATUS):  rd_byte = status;
            default:                     mapped  = 1'b0;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !mapped;
            prdata  <= (access && !pready && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // writes land only at the edge that completes the transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lbctl   <= T1LB_REG_RESET;
            chan_en <= {4{T1LB_REG_RESET}};
        end else if (commit && pwrite) begin
            case (paddr)
                // unused bits stored as written and read back as is
                t1lb_addr(T1LB_IDX_LBCTL):   lbctl          <= pwdata[7:0];
                t1lb_addr(T1LB_IDX_CH1_8):   chan_en[7:0]   <= pwdata[7:0];
                t1lb_addr(T1LB_IDX_CH9_16):  chan_en[15:8]  <= pwdata[7:0];
                t1lb_addr(T1LB_IDX_CH17_24): chan_en[23:16] <= pwdata[7:0];
                t1lb_addr(T1LB_IDX_CH25_32): chan_en[31:24] <= pwdata[7:0];
                default:                     ;
            endcase
        end
    end

endmodule

//--- bench/t1lb_line_model.sv
// Purpose: line-side partner with both line clocks and receive pairs
// Assumes: line clocks run at 80 ns with unrelated phase
// Notes:   data moves on falling rx clock, away from the sampled rise
`timescale 1ns/1ns
module t1lb_line_model (
    // level to send on the receive line; tie slaves the receive clock to transmit
    input  wire logic lvl,
    input  wire logic tie,
    // line clocks and receive pairs
    output logic      tx_line_clock,
    output logic      rx_recovered_clock_in,
    output logic      rx_line_pos_in,
    output logic      rx_line_neg_in,
    output logic      rx_analog_pos,
    output logic      rx_analog_neg
);
    logic rx_free;
    // clocks kept apart unless tied
    // own phase for receive: tying it to transmit is unstable in framer loop
    initial begin
        tx_line_clock = 1'b0;
        rx_free = 1'b0;
        fork
            forever #40 tx_line_clock = ~tx_line_clock;
            #17 forever #40 rx_free = ~rx_free;
        join
    end
    // per-channel loop runs with both clocks tied
    assign rx_recovered_clock_in = tie ? tx_line_clock : rx_free;
    // analog pair carries the inverse so the two sources tell apart
    initial {rx_line_pos_in, rx_line_neg_in, rx_analog_pos, rx_analog_neg} = 4'h9;
    always @(negedge rx_recovered_clock_in) begin
        {rx_line_pos_in, rx_line_neg_in, rx_analog_pos, rx_analog_neg} <= {lvl, ~lvl, ~lvl, lvl};
    end
endmodule

//--- bench/testbench.sv
// Purpose: register and steering checks for the loopback block
// Assumes: apb answer awaited with a bound; line clocks 80 ns
// Notes:   line waits are fixed, long enough for sync latency and two line edges
`timescale 1ns/1ns
module testbench import t1lb_pkg::*; ;
    // design pins
    logic                   pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, lvl, strobe;
    logic [T1LB_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata, prdata, rd;
    logic                   tx_line_clock, rx_recovered_clock_in, rx_line_pos_in, rx_line_neg_in, rx_analog_pos;
    logic                   rx_analog_neg, shared_mux_powerdown_pin, tx_line_pos_out, tx_line_neg_out, tx_power_down;
    logic                   line_unit_connected, tx_serial_in, tx_signaling_in, tx_channel_clock, tx_channel_block;
    logic                   e1_mode, fmt_overhead, rx_slot_data, rx_payload_fixed, tx_serial_to_fmt, tie;
    logic                   jitter_atten_tx_src, tx_signaling_to_fmt;
    logic [T1LB_SLOT_W-1:0] tx_slot;
    t1lb_pair_t             fmt_line, rx_to_framer;
    t1lb_mode_t             loop_mode, m;
    int                     miscompares, n_compared;
    // control byte and the mode that must win
    localparam logic [7:0]  CTL [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h0F, 8'h0B, 8'h09};
    localparam t1lb_mode_t  MD [8] = '{T1LB_NORMAL, T1LB_FRAMER, T1LB_PAYLOAD, T1LB_REMOTE, T1LB_LOCAL,
                                       T1LB_REMOTE, T1LB_PAYLOAD, T1LB_FRAMER};

    t1lb_top i_t1lb_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tx_line_clock, .rx_recovered_clock_in, .rx_line_pos_in, .rx_line_neg_in, .rx_analog_pos, .rx_analog_neg,
        .shared_mux_powerdown_pin, .tx_line_pos_out, .tx_line_neg_out, .tx_power_down, .line_unit_connected,
        .tx_serial_in, .tx_signaling_in, .tx_channel_clock, .tx_channel_block, .tx_link_clock(), .e1_mode, .fmt_line,
        .fmt_overhead, .tx_slot, .rx_slot_data, .rx_payload_fixed, .chan_clock_int(strobe), .chan_block_int(strobe),
        .tx_serial_to_fmt, .tx_signaling_to_fmt, .rx_to_framer, .rx_framer_tick(), .tx_framer_tick(),
        .jitter_atten_tx_src, .loop_mode);
    t1lb_line_model i_t1lb_line_model (.lvl, .tie, .tx_line_clock, .rx_recovered_clock_in, .rx_line_pos_in,
        .rx_line_neg_in, .rx_analog_pos, .rx_analog_neg);

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // verdict and end of run
    task automatic results();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; held until pready is sampled high at a rising edge, released right after it
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("BAD %0t apb timeout", $time);
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // let pin syncs and a couple of line edges pass, then look mid-cycle
    task automatic settle();
        repeat (24) @(posedge pclk);
        @(negedge pclk);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {shared_mux_powerdown_pin, tx_serial_in, e1_mode, fmt_overhead, tx_slot} = '0;
        {ce, rx_slot_data, rx_payload_fixed, strobe, lvl, tie, tx_signaling_in} = 7'h7F;
        fmt_line = 2'h1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 8'(T1LB_IDX_LBCTL + k), 8'h00);
            chk(rd, 32'h0, "reset value");
        end
        for (int k = 1; k < 5; k++) begin
            apb(1'b1, 8'(T1LB_IDX_LBCTL + k), 8'(1 << (k - 1)));
            apb(1'b0, 8'(T1LB_IDX_LBCTL + k), 8'h00);
            chk(rd, 32'(1 << (k - 1)), "channel reg");
        end
        apb(1'b0, 8'h50, 8'h00);
        chk(rd, 32'h0, "unmapped read");
        chk(32'(err), 32'h1, "unmapped error");
        $display("register test done");
        // one channel per register: slots 0, 9, 18, 27 take received data
        for (int s = 0; s < 32; s++) begin
            @(posedge pclk);
            tx_slot <= 5'(s);
            settle();
            chk(tx_serial_to_fmt, 32'(s % 9 == 0), "channel loop");
        end
        $display("channel test done");
        for (int k = 1; k < 5; k++) begin
            apb(1'b1, 8'(T1LB_IDX_LBCTL + k), 8'h00); // channel loop off before clocks part
        end
        tie <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            m = MD[i];
            apb(1'b1, T1LB_IDX_LBCTL, CTL[i]); // unused bits left zero
            apb(1'b0, T1LB_IDX_STATUS, 8'h00);
            settle();
            chk(rd[6:4], m, "mode");
            chk(loop_mode, m, "mode out");
            chk(tx_signaling_to_fmt, m != T1LB_PAYLOAD, "signaling");
            chk({tx_channel_clock, tx_channel_block}, m == T1LB_PAYLOAD ? 0 : 3, "chan strobes");
            chk(tx_serial_to_fmt, m == T1LB_PAYLOAD, "tx data");
            chk(jitter_atten_tx_src, m == T1LB_LOCAL, "jitter src");
            chk(rx_to_framer, (m == T1LB_FRAMER || m == T1LB_LOCAL) ? 1 : 2, "rx path");
            chk(m == T1LB_FRAMER ? {tx_line_pos_out ^ tx_line_neg_out, 1'b1} : {tx_line_pos_out, tx_line_neg_out},
                m == T1LB_REMOTE ? 2 : (m == T1LB_FRAMER ? 3 : 1), "line out");
        end
        $display("mode test done");
        @(posedge pclk);
        e1_mode <= 1'b1;
        apb(1'b1, T1LB_IDX_LBCTL, 8'h01);
        settle();
        chk({tx_line_pos_out, tx_line_neg_out}, 1, "e1 framer line");
        @(posedge pclk);
        fmt_overhead <= 1'b1;
        apb(1'b1, T1LB_IDX_LBCTL, 8'h02);
        settle();
        chk(tx_serial_to_fmt, 0, "overhead");
        $display("overhead test done");
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            shared_mux_powerdown_pin <= i[1];
            apb(1'b1, T1LB_IDX_LBCTL, {i[2], 2'h0, i[0], 4'h0});
            settle();
            chk(line_unit_connected, (i[2] | i[1]) & ~i[0], "mux");
            chk(tx_power_down, i[2] & i[1], "power down");
            chk(rx_to_framer, ((i[2] | i[1]) & ~i[0]) ? 1 : 2, "mux path");
        end
        $display("mux test done");
        results();
    end
endmodule
